// ===== src/sps_pkg.sv
// package: field layouts, mode codes and timing constants for the serial port
package sps_pkg;
  localparam int DATA_W = 8;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // mode-select codes, one per clock option and slave variant
  localparam logic [3:0] MODE_DIV4    = 4'h0;
  localparam logic [3:0] MODE_DIV16   = 4'h1;
  localparam logic [3:0] MODE_DIV64   = 4'h2;
  localparam logic [3:0] MODE_TMR2    = 4'h3;
  localparam logic [3:0] MODE_SLV_SS  = 4'h4;
  localparam logic [3:0] MODE_SLV     = 4'h5;
  localparam logic [3:0] MODE_RELOAD  = 4'ha;
  // half bit period in system clocks: oscillator divided by n gives n/2 per half
  localparam logic [7:0] HALF_DIV4    = 8'h02;
  localparam logic [7:0] HALF_DIV16   = 8'h08;
  localparam logic [7:0] HALF_DIV64   = 8'h20;
  // status register: two high bits writable, six low read-only
  localparam int STAT_SMP = 7;
  localparam int STAT_CKE = 6;
  localparam int STAT_BF  = 0;
  localparam logic [7:0] STAT_RW_MASK = 8'hc0;
  // control register one
  localparam int CON1_WRITE_COLLISION_FLAG = 7;
  localparam int CON1_EN   = 5;
  localparam int CON1_CKP  = 4;

  typedef struct packed {
    logic       enable;
    logic       clk_idle_high;
    logic [3:0] mode;
    logic       edge_sel;
    logic       sample_end;
    logic       overwrite_en;
  } sps_cfg_type;

  typedef struct packed {
    logic sck_in;
    logic sdi;
    logic ss_n;
  } sps_pins_in_type;

  typedef struct packed {
    logic sck_out;
    logic sck_oe;
    logic sdo_out;
    logic sdo_oe;
  } sps_pins_out_type;
endpackage : sps_pkg

// ===== src/sps_port.sv
// serial peripheral port, master or slave, byte wide
//
// Notes on behaviour
// - after eight bits, move byte to buffer, set buffer-full and transfer flag
// - buffer write loads the shift register at once; transmit unbuffered
// - shift out and in most significant bit first
// - receive double buffered; next byte may start before buffer read
// - without overwrite enable: write while shifting is dropped, sets collision; writes blocked until cleared
// - reading the data buffer clears buffer-full
// - port works only while enabled; reconfigure with enable cleared
// - master drives serial clock; slave takes it as input
// - master: buffer write starts a full-duplex byte at once
// - master keeps sampling input; each byte loads buffer with flags
// - master rate: osc/4, /16, /64, timer2/2 or osc/(4*(reload+1))
// - polarity bit sets serial clock idle level
// - edge bit picks output edge; set means data valid before first edge
// - sample bit picks middle or end of output time in master; slave always samples in middle
// - slave shifts on external clock; flag set when last bit latched
// - slave shifts while core sleeps; completed byte raises wake interrupt
// - daisy chain: resend received byte next group; one shared select
// - overwrite enable accepts buffer writes with unread byte
// - status: six low bits read-only, two high bits read-write
// - data in, select and slave clock inputs; data out, master clock outputs
// - select high with select control: stop driving output mid-byte
// - select high with select control, or enable clear, forces bit counter to zero
`timescale 1ns/1ps
module sps_port #(
  parameter int RELOAD_W = 8
) (
  // system
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // configuration
  input  wire sps_pkg::sps_cfg_type      cfg,
  input  wire logic [RELOAD_W-1:0]       rate_reload_value,
  input  wire logic                      timer2_tick,
  // software access to data buffer and flags
  input  wire logic                      buf_wr,
  input  wire logic [7:0]                buf_wdata,
  input  wire logic                      buf_rd,
  input  wire logic                      write_collision_flag_clr,
  input  wire logic                      irq_clr,
  output logic [7:0]                     shared_data_buffer,
  output logic [7:0]                     port_status_reg,
  output logic [7:0]                     port_control_reg_one,
  output logic                           transfer_irq_flag,
  output logic                           busy,
  // pins
  input  wire sps_pkg::sps_pins_in_type  pins_in,
  output sps_pkg::sps_pins_out_type      pins_out
);
  initial
  begin
    if (RELOAD_W < 1 || RELOAD_W > 16) $error("RELOAD_W out of range");
  end

  typedef enum logic [1:0] {SPS_IDLE, SPS_LEAD, SPS_TRAIL} sps_state_type;

  // decoding
  wire logic master    = (cfg.mode == sps_pkg::MODE_DIV4) || (cfg.mode == sps_pkg::MODE_DIV16) ||
                         (cfg.mode == sps_pkg::MODE_DIV64) || (cfg.mode == sps_pkg::MODE_TMR2) ||
                         (cfg.mode == sps_pkg::MODE_RELOAD);
  wire logic ss_ctl    = cfg.mode == sps_pkg::MODE_SLV_SS;
  wire logic mod_reset = !cfg.enable || (!master && ss_ctl && pins_in.ss_n);
  wire logic [16:0] half_rel = {1'b0, 16'(rate_reload_value)} + 17'h1;
  wire logic [16:0] half_len = (cfg.mode == sps_pkg::MODE_DIV4)  ? 17'(sps_pkg::HALF_DIV4)  :
                               (cfg.mode == sps_pkg::MODE_DIV16) ? 17'(sps_pkg::HALF_DIV16) :
                               (cfg.mode == sps_pkg::MODE_DIV64) ? 17'(sps_pkg::HALF_DIV64) :
                               {half_rel[15:0], 1'b0};

  sps_state_type state_q;
  logic [16:0] div_q;
  logic [2:0]  cnt_q;
  logic [7:0]  sr_q;
  logic        sdo_q;
  logic        sck_q;
  logic        samp_q;
  logic        mid_bit_q;
  logic        sck_in_q;
  logic        done_q;
  logic [7:0]  done_byte_q;
  logic        bf_q;
  logic        write_collision_flag_q;
  logic        irq_q;
  logic [7:0]  buf_q;

  // master half-period tick: counter or timer-2 pulse
  wire logic tick = (cfg.mode == sps_pkg::MODE_TMR2) ? timer2_tick
                                                      : (div_q + 17'h1 >= half_len);
  // slave: edge detect on externally driven clock sampled at system rate
  wire logic sck_rise  = pins_in.sck_in && !sck_in_q;
  wire logic sck_fall  = !pins_in.sck_in && sck_in_q;
  // leading edge leaves idle level, trailing edge returns to it
  wire logic lead_edge = cfg.clk_idle_high ? sck_fall : sck_rise;
  wire logic trail_edge = cfg.clk_idle_high ? sck_rise : sck_fall;
  // edge bit set: output changes on trailing edge, sample on leading
  wire logic shift_ev  = master ? (tick && (cfg.edge_sel ? state_q == SPS_TRAIL
                                                           : state_q == SPS_LEAD))
                                : (cfg.edge_sel ? trail_edge : lead_edge);
  wire logic sample_ev = master ? (tick && (cfg.edge_sel ? state_q == SPS_LEAD
                                                           : state_q == SPS_TRAIL))
                                : (cfg.edge_sel ? lead_edge : trail_edge);
  wire logic active    = master ? (state_q != SPS_IDLE) : (cnt_q != 3'h0);
  wire logic wr_ok     = buf_wr && !write_collision_flag_q && !active && cfg.enable;
  wire logic wr_coll   = buf_wr && cfg.enable && (active || write_collision_flag_q) && !cfg.overwrite_en;
  wire logic wr_take   = wr_ok || (buf_wr && cfg.enable && !active && cfg.overwrite_en);
  // sample taken in middle or at end of output time
  wire logic samp_now  = (master && cfg.sample_end) ? shift_ev : sample_ev;
  wire logic byte_end  = master ? (tick && state_q == SPS_TRAIL && cnt_q == sps_pkg::BIT_LAST)
                                : (sample_ev && cnt_q == sps_pkg::BIT_LAST);
  wire logic [7:0] rx_byte = {sr_q[6:0], master && cfg.sample_end ? samp_q : pins_in.sdi};
  // with sampling on the leading edge the byte is already complete at the last trailing edge
  wire logic [7:0] byte_val = sample_ev ? rx_byte : sr_q;

  // bit clock state and divider
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= SPS_IDLE;
      div_q   <= 17'h0;
      cnt_q   <= 3'h0;
    end
    else if (mod_reset)
    begin
      state_q <= SPS_IDLE;
      div_q   <= 17'h0;
      cnt_q   <= 3'h0;
    end
    else if (master)
    begin
      div_q <= (state_q == SPS_IDLE || tick) ? 17'h0 : div_q + 17'h1;
      case (state_q)
        SPS_IDLE:  state_q <= wr_take ? SPS_LEAD : SPS_IDLE;
        SPS_LEAD:  state_q <= tick ? SPS_TRAIL : SPS_LEAD;
        SPS_TRAIL:
        begin
          if (tick)
          begin
            state_q <= (cnt_q == sps_pkg::BIT_LAST) ? SPS_IDLE : SPS_LEAD;
            cnt_q   <= cnt_q + 3'h1;
          end
        end
        default:   state_q <= SPS_IDLE;
      endcase
    end
    else if (sample_ev)
    begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  // shift register and pins
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sr_q      <= 8'h00;
      sdo_q     <= 1'b0;
      sck_q     <= 1'b0;
      samp_q    <= 1'b0;
      mid_bit_q <= 1'b0;
      sck_in_q  <= 1'b0;
    end
    else
    begin
      sck_in_q <= pins_in.sck_in;
      mid_bit_q <= cfg.edge_sel;
      // clock leaves idle at the leading tick and returns at the trailing tick
      sck_q    <= (master && ((state_q == SPS_LEAD && tick) || (state_q == SPS_TRAIL && !tick)))
                  ? !cfg.clk_idle_high : cfg.clk_idle_high;
      if (samp_now)
        samp_q <= pins_in.sdi;
      if (wr_take)
      begin
        sr_q  <= buf_wdata;
        sdo_q <= buf_wdata[7];
      end
      else if (sample_ev && !mod_reset)
        sr_q <= rx_byte;
      else if (shift_ev && !mod_reset && (master || cnt_q != 3'h0 || cfg.edge_sel))
        sdo_q <= sr_q[7];
    end
  end

  // completed byte crosses into flag logic one cycle later
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      done_q      <= 1'b0;
      done_byte_q <= 8'h00;
    end
    else
    begin
      done_q      <= byte_end && !mod_reset;
      done_byte_q <= byte_end ? byte_val : done_byte_q;
    end
  end

  // buffer and flags; hardware set beats software clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      buf_q  <= 8'h00;
      bf_q   <= 1'b0;
      write_collision_flag_q <= 1'b0;
      irq_q  <= 1'b0;
    end
    else
    begin
      if (done_q)
        buf_q <= done_byte_q;
      else if (wr_take)
        buf_q <= buf_wdata;
      bf_q   <= done_q || (bf_q && !buf_rd);
      irq_q  <= done_q || (irq_q && !irq_clr);
      write_collision_flag_q <= wr_coll || (write_collision_flag_q && !write_collision_flag_clr);
    end
  end

  // outputs, all registered
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shared_data_buffer   <= 8'h00;
      port_status_reg      <= 8'h00;
      port_control_reg_one <= 8'h00;
      transfer_irq_flag    <= 1'b0;
      busy                 <= 1'b0;
      pins_out             <= '0;
    end
    else
    begin
      shared_data_buffer   <= done_q ? done_byte_q : (wr_take ? buf_wdata : buf_q);
      port_status_reg      <= {cfg.sample_end, cfg.edge_sel, 5'h00,
                               done_q || (bf_q && !buf_rd)};
      port_control_reg_one <= {wr_coll || (write_collision_flag_q && !write_collision_flag_clr), 1'b0, cfg.enable,
                               cfg.clk_idle_high, cfg.mode};
      transfer_irq_flag    <= done_q || (irq_q && !irq_clr);
      busy                 <= active;
      pins_out.sck_out     <= master ? sck_q : cfg.clk_idle_high;
      pins_out.sck_oe      <= cfg.enable && master;
      pins_out.sdo_out     <= sdo_q;
      pins_out.sdo_oe      <= cfg.enable && !(ss_ctl && !master && pins_in.ss_n);
    end
  end
endmodule : sps_port

// ===== bench/sps_port_asserts.sv
// checker: flag, pin and timing relations at the serial port boundary
`timescale 1ns/1ps
module sps_port_asserts (
  // system
  input wire logic                      clk,
  input wire logic                      rst_n,
  // software side
  input wire sps_pkg::sps_cfg_type      cfg,
  input wire logic                      buf_wr,
  input wire logic                      buf_rd,
  input wire logic [7:0]                port_status_reg,
  input wire logic [7:0]                port_control_reg_one,
  input wire logic                      transfer_irq_flag,
  input wire logic                      busy,
  // pins
  input wire sps_pkg::sps_pins_in_type  pins_in,
  input wire sps_pkg::sps_pins_out_type pins_out
);
  logic mst;
  assign mst = cfg.enable && (cfg.mode < 4'h4 || cfg.mode == sps_pkg::MODE_RELOAD);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  start_busy_a: assert property (buf_wr && mst && !busy && !port_control_reg_one[7] |-> ##2 busy)
    else $error("accepted write did not start a byte");
  collide_set_a: assert property (buf_wr && busy && cfg.enable && !cfg.overwrite_en
    |=> port_control_reg_one[7])
    else $error("write while shifting did not flag a collision");
  collide_block_a: assert property (buf_wr && !busy && port_control_reg_one[7]
    && !cfg.overwrite_en |-> ##2 !busy)
    else $error("write accepted while collision flag set");
  clock_dir_a: assert property (cfg.enable ##1 $stable(cfg) |-> pins_out.sck_oe == mst)
    else $error("serial clock direction wrong for mode");
  idle_level_a: assert property ((mst && !busy && $stable(cfg))[*3]
    |-> pins_out.sck_out == cfg.clk_idle_high)
    else $error("serial clock not at idle level");
  byte_done_a: assert property ($fell(busy) && mst |-> ##[0:4] (transfer_irq_flag
    && port_status_reg[0]))
    else $error("finished byte did not set both flags");
  full_clear_a: assert property (buf_rd && !busy && mst |=> !port_status_reg[0])
    else $error("buffer read did not clear full flag");
  status_bits_a: assert property ($stable(cfg) ##1 $stable(cfg)
    |-> port_status_reg[7:1] == {cfg.sample_end, cfg.edge_sel, 5'h00})
    else $error("status register bits wrong");
  control_bits_a: assert property ($stable(cfg) ##1 $stable(cfg) |-> port_control_reg_one[6:0]
    == {1'b0, cfg.enable, cfg.clk_idle_high, cfg.mode})
    else $error("control register bits wrong");
  select_off_a: assert property (cfg.enable && cfg.mode == sps_pkg::MODE_SLV_SS && pins_in.ss_n
    |=> !pins_out.sdo_oe)
    else $error("data out driven while deselected");
endmodule : sps_port_asserts

bind sps_port sps_port_asserts sps_port_asserts_i (.clk(clk), .rst_n(rst_n), .cfg(cfg),
  .buf_wr(buf_wr), .buf_rd(buf_rd), .port_status_reg(port_status_reg),
  .port_control_reg_one(port_control_reg_one), .transfer_irq_flag(transfer_irq_flag),
  .busy(busy), .pins_in(pins_in), .pins_out(pins_out));

// ===== bench/sps_slave_model.sv
// partner: serial slave that answers a master byte
`timescale 1ns/1ps
module sps_slave_model (
  // serial side
  input  wire logic       sck,
  input  wire logic       idle_high,
  input  wire logic       sdo,
  output logic            sdi,
  // bench side
  input  wire logic       load,
  input  wire logic [7:0] preset,
  output logic [7:0]      rx_byte
);
  logic       lead;
  logic [7:0] tx;
  assign lead = sck ^ idle_high;
  assign sdi = tx[7];
  // sample on leading edge, change on trailing edge
  always @(posedge lead) rx_byte <= {rx_byte[6:0], sdo};
  always @(negedge lead or posedge load)
  begin
    if (load)
      tx <= preset;
    else
      tx <= {tx[6:0], tx[7]};
  end
endmodule : sps_slave_model

// ===== bench/spi_master_slave_port_tb_top.sv
// testbench: master rates, collisions, overwrite, enable and pin roles
`timescale 1ns/1ps
module spi_master_slave_port_tb_top;
  logic                      clk = 1'b0;
  logic                      rst_n = 1'b0;
  sps_pkg::sps_cfg_type      cfg = '0;
  logic                      t2 = 1'b0;
  logic                      wr = 1'b0;
  logic                      rd = 1'b0;
  logic                      wclr = 1'b0;
  logic                      iclr = 1'b0;
  logic                      load = 1'b0;
  logic                      ss_n = 1'b1;
  logic [7:0]                wdata = 8'h00;
  logic [7:0]                pre = 8'h00;
  logic [7:0]                rx_s, dbuf, stat, ctl;
  logic                      irq, busy, sdi;
  sps_pkg::sps_pins_in_type  pin_i;
  sps_pkg::sps_pins_out_type pin_o;
  logic [3:0]                md [5] = '{sps_pkg::MODE_DIV4, sps_pkg::MODE_DIV16,
    sps_pkg::MODE_DIV64, sps_pkg::MODE_RELOAD, sps_pkg::MODE_TMR2};
  int                        hv [5] = '{2, 8, 32, 8, 5};
  int                        err_total = 0;
  int                        n_compared = 0;
  int                        cyc = 0;
  int                        n;
  always #10 clk = ~clk;
  // slave clock input held at idle low
  assign pin_i = {1'b0, sdi, ss_n};
  always @(negedge clk)
  begin
    cyc <= cyc + 1;
    t2 <= cyc % 5 == 4;
  end
  sps_port sps_port_i (.clk(clk), .rst_n(rst_n), .cfg(cfg), .rate_reload_value(8'h03),
    .timer2_tick(t2), .buf_wr(wr), .buf_wdata(wdata), .buf_rd(rd), .write_collision_flag_clr(wclr),
    .irq_clr(iclr), .shared_data_buffer(dbuf), .port_status_reg(stat),
    .port_control_reg_one(ctl), .transfer_irq_flag(irq), .busy(busy), .pins_in(pin_i),
    .pins_out(pin_o));
  sps_slave_model sps_slave_model_i (.sck(pin_o.sck_out), .idle_high(cfg.clk_idle_high),
    .sdo(pin_o.sdo_out), .sdi(sdi), .load(load), .preset(pre), .rx_byte(rx_s));
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse
  task automatic wr_byte(input logic [7:0] d);
    wdata = d;
    pulse(wr);
  endtask : wr_byte
  task automatic wait_irq;
    n = 0;
    while (irq !== 1'b1)
    begin
      @(negedge clk);
      n++;
      if (n > 1500)
      begin
        err_total++;
        end_of_test();
      end
    end
  endtask : wait_irq
  task automatic ack;
    @(negedge clk);
    rd = 1'b1;
    pulse(iclr);
    rd = 1'b0;
    @(negedge clk);
    chk("full clear", 1'b0, stat[0]);
  endtask : ack
  task automatic xfer(input logic [7:0] d, input logic [7:0] p, input int h);
    pre = p;
    load = 1'b1;
    #1 load = 1'b0;
    wr_byte(d);
    wait_irq();
    chk("rate", 1'b1, n >= 15 * h && n <= 16 * h + 8);
    chk("sent", d, rx_s);
    chk("received", p, dbuf);
    chk("full", 1'b1, stat[0]);
  endtask : xfer
  initial
  begin
    repeat (5) @(negedge clk);
    chk("reset", 24'h0, {dbuf, stat, ctl});
    rst_n = 1'b1;
    foreach (md[i])
    begin
      cfg = {1'b0, i[0], md[i], 1'b1, 2'b00};
      @(negedge clk);
      cfg.enable = 1'b1;
      repeat (3) @(negedge clk);
      chk("control", {3'h1, i[0], md[i]}, ctl);
      chk("status", 8'h40, stat);
      chk("clock pin", {1'b1, i[0]}, {pin_o.sck_oe, pin_o.sck_out});
      xfer(8'ha5 ^ i[7:0], 8'h3c + i[7:0], hv[i]);
      ack();
    end
    $display("rates done");
    wr_byte(8'h81);
    wr_byte(8'h7e);
    chk("collision", 1'b1, ctl[7]);
    wait_irq();
    chk("kept", 8'h81, rx_s);
    ack();
    wr_byte(8'h55);
    @(negedge clk);
    chk("blocked", 1'b0, busy);
    pulse(wclr);
    wr_byte(8'h12);
    wr_byte(8'h99);
    wait_irq();
    pulse(iclr);
    cfg.overwrite_en = 1'b1;
    wr_byte(8'h34);
    @(negedge clk);
    chk("overwrite", 1'b1, busy);
    wait_irq();
    chk("overwrite sent", 8'h34, rx_s);
    ack();
    $display("collision done");
    cfg.enable = 1'b0;
    wr_byte(8'h66);
    @(negedge clk);
    chk("disabled", 1'b0, busy);
    cfg = {1'b1, 1'b0, sps_pkg::MODE_SLV_SS, 1'b1, 2'b00};
    repeat (3) @(negedge clk);
    chk("slave pins", 2'b00, {pin_o.sck_oe, pin_o.sdo_oe});
    ss_n = 1'b0;
    repeat (3) @(negedge clk);
    chk("selected out", 1'b1, pin_o.sdo_oe);
    $display("pins done");
    end_of_test();
  end
endmodule : spi_master_slave_port_tb_top
